// ==== verilog/dp_port_cfg.svh ====
`ifndef DP_PORT_CFG_SVH
`define DP_PORT_CFG_SVH
// Function
// - The host selects the array with array select low and token-latch select high, the latches the other way, and holds that choice until the write ends.
// - The host keeps the write strobe high during every read cycle.
// - The host keeps the write strobe high whenever the address lines change.
// - With output enable low the write pulse must last the longer of the minimum pulse and turn-off plus data set-up, with it high the minimum pulse is enough.
// - In slave use the host keeps the write strobe high until a hold time after busy returns high.
// - After a latch write the host keeps the latch select or output enable high for a flag update pulse before reading it back.

// ----------------------------------------------------------------
// Clock and pin timing
// ----------------------------------------------------------------
`define DP_CLK_PERIOD_NS 40
`define DP_WRITE_PULSE_NS 12
`define DP_STROBE_TO_HIZ_NS 10
`define DP_DATA_SETUP_NS 10
`define DP_SELECT_TO_END_NS 12
`define DP_SLAVE_WRITE_HOLD_NS 13
`define DP_FLAG_UPDATE_PULSE_NS 10
`define DP_PRIORITY_SETUP_NS 5
`define DP_SELECT_ACCESS_NS 15
`define DP_SYNC_STAGES 2

// Least times round up to whole cycles
`define DP_CEIL_CYC(ns) (((ns) + `DP_CLK_PERIOD_NS - 1) / `DP_CLK_PERIOD_NS)
`define DP_PULSE_CYC `DP_CEIL_CYC(`DP_WRITE_PULSE_NS)
`define DP_HIZ_SETUP_CYC `DP_CEIL_CYC(`DP_STROBE_TO_HIZ_NS + `DP_DATA_SETUP_NS)
`define DP_HOLD_CYC `DP_CEIL_CYC(`DP_SLAVE_WRITE_HOLD_NS)
`define DP_GAP_CYC `DP_CEIL_CYC(`DP_FLAG_UPDATE_PULSE_NS)
`define DP_ACCESS_CYC `DP_CEIL_CYC(`DP_SELECT_ACCESS_NS)

// ----------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------
`define DP_ADDR_W 17
`define DP_DATA_W 9

`endif

// ==== verilog/dp_port_pkg.sv ====
`include "dp_port_cfg.svh"
package dp_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WAIT_BUSY,
    ST_STROBE,
    ST_HOLD
  } state_e;

  typedef struct packed {
    logic write;
    logic to_latch;
    logic [`DP_ADDR_W-1:0] addr;
    logic [`DP_DATA_W-1:0] wdata;
  } cmd_s;

  typedef struct packed {
    state_e st;
    logic [7:0] cnt;
    logic [7:0] bcnt;
    logic [7:0] gap;
    logic ready;
    logic done;
    logic ce_n;
    logic latch_sel_n;
    logic rw_n;
    logic oe_n;
    logic data_oe;
    logic [`DP_ADDR_W-1:0] addr;
    logic [`DP_DATA_W-1:0] wdata;
    logic [`DP_DATA_W-1:0] rdata;
  } ctl_s;

endpackage

// ==== verilog/dp_sync2.sv ====
`timescale 1ns/1ns
module dp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ----------------------------------------------------------------
  // Two-stage synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i)
  begin
    meta_q <= d_i;
    q_o <= meta_q;
  end
endmodule // dp_sync2

// ==== verilog/dp_port_host.sv ====
`timescale 1ns/1ns
`include "dp_port_cfg.svh"
module dp_port_host #(
  parameter logic [7:0] PULSE_CYC = 8'(`DP_PULSE_CYC),
  parameter logic [7:0] HOLD_CYC = 8'(`DP_HOLD_CYC),
  parameter logic [7:0] GAP_CYC = 8'(`DP_GAP_CYC),
  parameter logic [7:0] ACCESS_CYC = 8'(`DP_ACCESS_CYC)
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire dp_port_pkg::cmd_s cmd_i,
  output logic ready_o,
  output logic done_o,
  output logic [`DP_DATA_W-1:0] rdata_o,
  input wire logic busy_n_i,
  output logic ce_n_o,
  output logic token_latch_select_n_o,
  output logic rw_n_o,
  output logic oe_n_o,
  output logic [`DP_ADDR_W-1:0] addr_o,
  input wire logic [`DP_DATA_W-1:0] data_i,
  output logic [`DP_DATA_W-1:0] data_o,
  output logic data_oe_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic busy_n_s;
  logic [`DP_DATA_W-1:0] data_s;

  // Busy and data share one synchroniser; read data is taken long after the pins settle
  dp_sync2 #(.W(`DP_DATA_W + 1)) u_sync (
    .clk_i(clk_i),
    .d_i({busy_n_i, data_i}),
    .q_o({busy_n_s, data_s})
  );

  // Read data is sampled after the select access time plus the synchroniser delay
  // A slower part needs a larger access count; the read length follows it, but read_time_a and the read covers keep a fixed 5-cycle delay
  localparam logic [7:0] READ_LAST = 8'(ACCESS_CYC + 8'(`DP_SYNC_STAGES));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  dp_port_pkg::ctl_s q;
  dp_port_pkg::ctl_s d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    unique case (q.st)
      dp_port_pkg::ST_IDLE:
      begin
        if (q.gap != 8'h00)
        begin
          d.gap = q.gap - 8'h01;
        end
        else if (req_i && q.ready)
        begin
          // Address moves only here, with the strobe high, and at reset, which clears it to zero
          d.addr = cmd_i.addr;
          d.wdata = cmd_i.wdata;
          d.ce_n = cmd_i.to_latch;
          d.latch_sel_n = !cmd_i.to_latch;
          d.rw_n = 1'b1;
          // Writes keep output enable high so the plain minimum pulse holds
          d.oe_n = cmd_i.write;
          d.data_oe = cmd_i.write;
          d.cnt = 8'h00;
          d.bcnt = 8'h00;
          d.st = cmd_i.write ? dp_port_pkg::ST_WAIT_BUSY : dp_port_pkg::ST_READ;
        end
      end
      dp_port_pkg::ST_READ:
      begin
        if (q.cnt >= READ_LAST)
        begin
          d.rdata = data_s;
          d.done = 1'b1;
          d.ce_n = 1'b1;
          d.latch_sel_n = 1'b1;
          d.oe_n = 1'b1;
          d.gap = GAP_CYC;
          d.st = dp_port_pkg::ST_IDLE;
        end
        else
        begin
          d.cnt = q.cnt + 8'h01;
        end
      end
      dp_port_pkg::ST_WAIT_BUSY:
      begin
        // Any low busy restarts the hold count
        if (!busy_n_s)
        begin
          d.bcnt = 8'h00;
        end
        else
        begin
          d.bcnt = (q.bcnt == 8'hFF) ? q.bcnt : q.bcnt + 8'h01;
          if (q.bcnt + 8'h01 >= HOLD_CYC)
          begin
            d.rw_n = 1'b0;
            d.cnt = 8'h01;
            d.st = dp_port_pkg::ST_STROBE;
          end
        end
      end
      dp_port_pkg::ST_STROBE:
      begin
        if (q.cnt >= PULSE_CYC)
        begin
          d.rw_n = 1'b1;
          d.st = dp_port_pkg::ST_HOLD;
        end
        else
        begin
          d.cnt = q.cnt + 8'h01;
        end
      end
      dp_port_pkg::ST_HOLD:
      begin
        // Select released only after the strobe has ended the write
        d.ce_n = 1'b1;
        d.latch_sel_n = 1'b1;
        d.data_oe = 1'b0;
        d.done = 1'b1;
        // Deselect gap also covers latch read-back after a latch write
        d.gap = GAP_CYC;
        d.st = dp_port_pkg::ST_IDLE;
      end
    endcase
    // Ready drops in the take cycle so a held request is not taken twice
    d.ready = (d.st == dp_port_pkg::ST_IDLE) && (d.gap == 8'h00) && !(req_i && q.ready);
    // Reset wins over any access, so an aborted one leaves every strobe high
    if (!resetn_i)
    begin
      d = '0;
      d.st = dp_port_pkg::ST_IDLE;
      d.ce_n = 1'b1;
      d.latch_sel_n = 1'b1;
      d.rw_n = 1'b1;
      d.oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign ready_o = q.ready;
  assign done_o = q.done;
  assign rdata_o = q.rdata;
  assign ce_n_o = q.ce_n;
  assign token_latch_select_n_o = q.latch_sel_n;
  assign rw_n_o = q.rw_n;
  assign oe_n_o = q.oe_n;
  assign addr_o = q.addr;
  assign data_o = q.wdata;
  assign data_oe_o = q.data_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  select_combo_a: assert property (!rw_n_o |-> (ce_n_o != token_latch_select_n_o) && $stable(ce_n_o))
    else $error("select combination invalid or moving during write");
  select_held_a: assert property ($rose(rw_n_o) |-> !(ce_n_o && token_latch_select_n_o))
    else $error("select released before write end");
  read_strobe_a: assert property (!oe_n_o |-> rw_n_o)
    else $error("write strobe low during read");
  addr_quiet_a: assert property (!$stable(addr_o) |-> rw_n_o && $past(rw_n_o))
    else $error("address changed with write strobe low");
  pulse_width_a: assert property ($rose(rw_n_o) |-> !$past(rw_n_o, PULSE_CYC) && oe_n_o)
    else $error("write pulse too short");
  no_fight_a: assert property (data_oe_o |-> oe_n_o)
    else $error("host drives data while device output enabled");
  busy_hold_a: assert property ($fell(rw_n_o) |-> q.bcnt >= HOLD_CYC && $past(busy_n_s))
    else $error("write started too soon after busy release");
  latch_gap_a: assert property ($rose(token_latch_select_n_o) |-> !ready_o ##1 token_latch_select_n_o)
    else $error("latch reselected without update gap");
  read_time_a: assert property (req_i && ready_o && !cmd_i.write |-> ##5 done_o && oe_n_o)
    else $error("read did not finish on time");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  strobe_select_a: assert property ($fell(rw_n_o) |-> $past(ce_n_o != token_latch_select_n_o))
    else $error("write strobe fell before a select was chosen");
  hold_release_a: assert property (q.st == dp_port_pkg::ST_HOLD |-> ce_n_o != token_latch_select_n_o)
    else $error("select dropped before the write ended");
  addr_hold_a: assert property ($rose(rw_n_o) |-> $stable(addr_o))
    else $error("address moved at write end");
  data_setup_a: assert property (!rw_n_o |-> data_oe_o && $stable(data_o))
    else $error("write data not set up across the strobe");
  write_oe_a: assert property (!data_oe_o |-> rw_n_o)
    else $error("write strobe low without write data driven");
  read_pins_a: assert property (q.st == dp_port_pkg::ST_READ |-> !oe_n_o && rw_n_o && !data_oe_o)
    else $error("read cycle pins wrong");
  ready_idle_a: assert property (ready_o |-> ce_n_o && token_latch_select_n_o && rw_n_o && !data_oe_o)
    else $error("ready shown while the port is still active");
  // Busy checks use the synchronised copy, the one the sequencer acts on
  busy_block_a: assert property (!busy_n_s && rw_n_o |=> rw_n_o)
    else $error("write strobe fell while busy was low");
  // The deselect gap must already be counting when done is shown
  gap_idle_a: assert property (done_o |-> ce_n_o && token_latch_select_n_o && !ready_o)
    else $error("select not released at the end of an access");

  // ----------------------------------------------------------------
  // Scenario covers
  // ----------------------------------------------------------------
  array_write_c: cover property (req_i && ready_o && cmd_i.write && !cmd_i.to_latch ##[4:20] done_o);
  latch_write_c: cover property (req_i && ready_o && cmd_i.write && cmd_i.to_latch ##[4:20] done_o);
  array_read_c: cover property (req_i && ready_o && !cmd_i.write ##5 done_o);
  busy_stall_c: cover property (q.st == dp_port_pkg::ST_WAIT_BUSY && !busy_n_s ##1 busy_n_s);
  latch_read_c: cover property (req_i && ready_o && !cmd_i.write && cmd_i.to_latch ##5 done_o);
endmodule // dp_port_host

// ==== verif/dp_sram_model.sv ====
`timescale 1ns/1ns
`include "dp_port_cfg.svh"
module dp_sram_model #(
  parameter bit MASTER = 1'b1
) (
  input wire logic ce_n_i,
  input wire logic token_latch_select_n_i,
  input wire logic rw_n_i,
  input wire logic oe_n_i,
  input wire logic [`DP_ADDR_W-1:0] addr_i,
  input wire logic [`DP_DATA_W-1:0] data_i,
  input wire logic clash_i,
  output logic [`DP_DATA_W-1:0] data_o,
  output logic busy_n_o
);
  logic [`DP_DATA_W-1:0] mem [logic [`DP_ADDR_W-1:0]];
  logic [7:0] latch_q = 8'hFF;
  logic [`DP_DATA_W-1:0] last_q = '0;
  logic [`DP_DATA_W-1:0] rd_val;
  logic wr_on;
  logic drive;
  // ----------------------------------------
  // Write and read paths
  // ----------------------------------------
  assign wr_on = ~rw_n_i & (~ce_n_i | ~token_latch_select_n_i);
  always @(negedge wr_on)
  begin
    if (!ce_n_i)
      mem[addr_i] = data_i;
    else if (!token_latch_select_n_i)
      latch_q[addr_i[2:0]] = data_i[0];
  end
  assign rd_val = !ce_n_i ? (mem.exists(addr_i) ? mem[addr_i] : '0) : {8'hFF, latch_q[addr_i[2:0]]};
  // Outputs only while strobe is high, so a select under a low strobe stays off the bus
  assign drive = ~oe_n_i & rw_n_i & (ce_n_i ^ token_latch_select_n_i);
  always @*
    if (drive)
      last_q = rd_val;
  // Released pins show the inverse of the last value, never a stale copy
  assign data_o = drive ? rd_val : ~last_q;
  // The far port is stood in for by clash_i; this port is the single loser
  assign busy_n_o = MASTER ? ~clash_i : 1'b1;
endmodule // dp_sram_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`include "dp_port_cfg.svh"
module testbench;
  typedef struct packed {
    dp_port_pkg::cmd_s cmd;
    logic [`DP_DATA_W-1:0] exp;
  } row_s;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic clash = 1'b0;
  dp_port_pkg::cmd_s cmd = '0;
  logic busy_n, rdy, done, ce_n, lsel_n, rw_n, oe_n, doe;
  logic [`DP_ADDR_W-1:0] addr;
  logic [`DP_DATA_W-1:0] rdata, hdata, mdata, pin;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int lat;
  row_s rows [9] = '{
    '{'{1'b1, 1'b0, 17'h00000, 9'h1A5}, 9'h000}, '{'{1'b1, 1'b0, 17'h1FFFF, 9'h05A}, 9'h000},
    '{'{1'b0, 1'b0, 17'h00000, 9'h000}, 9'h1A5}, '{'{1'b0, 1'b0, 17'h1FFFF, 9'h000}, 9'h05A},
    '{'{1'b1, 1'b1, 17'h00003, 9'h000}, 9'h000}, '{'{1'b0, 1'b1, 17'h00003, 9'h000}, 9'h1FE},
    '{'{1'b1, 1'b1, 17'h00003, 9'h001}, 9'h000}, '{'{1'b0, 1'b1, 17'h00003, 9'h000}, 9'h1FF},
    '{'{1'b0, 1'b0, 17'h00005, 9'h000}, 9'h000}};
  always #20 clk = ~clk;
  assign pin = doe ? hdata : mdata;
  dp_port_host i_dp_port_host (.clk_i(clk), .resetn_i(resetn), .req_i(req), .cmd_i(cmd), .ready_o(rdy),
    .done_o(done), .rdata_o(rdata), .busy_n_i(busy_n), .ce_n_o(ce_n), .token_latch_select_n_o(lsel_n),
    .rw_n_o(rw_n), .oe_n_o(oe_n), .addr_o(addr), .data_i(pin), .data_o(hdata), .data_oe_o(doe));
  dp_sram_model i_dp_sram_model (.ce_n_i(ce_n), .token_latch_select_n_i(lsel_n), .rw_n_i(rw_n),
    .oe_n_i(oe_n), .addr_i(addr), .data_i(pin), .clash_i(clash), .data_o(mdata), .busy_n_o(busy_n));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One command; lat counts edges from take to done
  task automatic do_op(input dp_port_pkg::cmd_s c);
    while (rdy !== 1'b1)
      @(posedge clk) #1;
    req = 1'b1;
    cmd = c;
    @(posedge clk) #1;
    req = 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 40)
    begin
      if (c.write)
        check("oe_n in write", 9'(oe_n), 9'h001);
      else
        check("rw_n in read", 9'(rw_n), 9'h001);
      if (!(ce_n & lsel_n))
        check("select pair", 9'({ce_n, lsel_n}), c.to_latch ? 9'h002 : 9'h001);
      @(posedge clk) #1;
      lat++;
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (20)
      @(posedge clk);
    #1;
    check("ready in reset", 9'(rdy), 9'h000);
    check("pins in reset", 9'({ce_n, lsel_n, rw_n, oe_n, doe}), 9'h01E);
    resetn = 1'b1;
    foreach (rows[i])
    begin
      do_op(rows[i].cmd);
      check("latency", 9'(lat), rows[i].cmd.write ? 9'h003 : 9'h004);
      if (!rows[i].cmd.write)
        check("read data", rdata, rows[i].exp);
    end
    // Busy held low across a write: the strobe must wait for its release
    clash = 1'b1;
    fork
      do_op('{1'b1, 1'b0, 17'h00007, 9'h133});
      begin
        repeat (12)
        begin
          @(posedge clk) #1;
          check("strobe under busy", 9'(rw_n), 9'h001);
        end
        clash = 1'b0;
      end
    join
    check("busy stretches write", 9'(lat > 12 && lat < 40), 9'h001);
    do_op('{1'b0, 1'b0, 17'h00007, 9'h000});
    check("data after busy", rdata, 9'h133);
    // Reset in mid-read: pins return to idle and stored data survives
    while (rdy !== 1'b1)
      @(posedge clk) #1;
    req = 1'b1;
    cmd = '{1'b0, 1'b0, 17'h00000, 9'h000};
    @(posedge clk) #1;
    req = 1'b0;
    @(posedge clk) #1;
    resetn = 1'b0;
    repeat (2)
      @(posedge clk) #1;
    check("pins in mid reset", 9'({ce_n, lsel_n, rw_n, oe_n, doe}), 9'h01E);
    check("ready done in reset", 9'({rdy, done}), 9'h000);
    check("rdata in reset", rdata, 9'h000);
    resetn = 1'b1;
    @(posedge clk) #1;
    check("ready after reset", 9'(rdy), 9'h001);
    do_op('{1'b0, 1'b0, 17'h00000, 9'h000});
    check("data after reset", rdata, 9'h1A5);
    print_verdict();
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      print_verdict();
    end
  end
endmodule // testbench
